// *** verilog/ufl_top.sv ***
`timescale 1ns/10ps
// How it works
// - Three interrupt lines: transmit, receive, error.
// - Every source has its own enable; flags pollable.
// - Transmit-empty interrupt stands while buffer empty.
// - Done flag sets only when transmitter idle.
// - Receive-full clears by status read, data read.
// - Idle clears likewise; rearms after a new character.
// - Character errors set together with receive-full.
// - Overrun sets; new character and errors dropped.
// - Receive falling edge sets edge flag while receiver on; write-one clears.
// - Nine-bit mode adds ninth bit both ways.
// - Ninth transmit bit copied with byte at load.
// - Stop1/stop2 lose state; stop3 freezes and resumes.
// - Edge detector wakes from stop3 when enabled.
// - Loop mode feeds transmitter into receiver internally.
// - Single-wire mode: receiver hears transmitter and pin.
// - Direction bit chooses drive or listen on pin.
// - Single-wire receiver also captures own transmissions.
module ufl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ufl_pkg::ADDR_W-1:0] paddr,
   input wire logic [ufl_pkg::DATA_W-1:0] pwdata,
   output logic [ufl_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_load,
   input wire logic tx_idle,
   input wire logic tx_serial,
   output logic tx_buf_valid,
   output logic [8:0] tx_shift_data,
   input wire logic rx_char_ready,
   input wire logic [8:0] rx_char,
   input wire logic rx_noise_err,
   input wire logic rx_frame_err,
   input wire logic rx_parity_err,
   input wire logic rx_idle_detect,
   input wire logic break_detect,
   output logic rx_serial,
   output logic rx_enable,
   output logic nine_bit_mode,
   input wire logic serial_in_pin,
   output logic serial_in_released,
   input wire logic serial_out_i,
   output logic serial_out_o,
   output logic serial_out_oe,
   input wire logic [1:0] stop_mode,
   output logic wake_req,
   output logic irq_tx,
   output logic irq_rx,
   output logic irq_err
);
   import ufl_pkg::*;

   logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, ctrl3_q, ctrl3_d;
   logic [7:0] tx_buf_q, tx_buf_d, rx_data_q, rx_data_d;
   logic [8:0] tx_shift_q, tx_shift_d;
   logic rx_ninth_q, rx_ninth_d;
   logic txe_q, txe_d, tc_q, tc_d, rx_buffer_full_q, rx_buffer_full_d, idle_q, idle_d;
   logic ovr_q, ovr_d, nf_q, nf_d, fe_q, fe_d, pf_q, pf_d;
   logic edge_q, edge_d, brk_q, brk_d, idle_arm_q, idle_arm_d, rx_prev_q, rx_prev_d;
   logic [5:0] seen_q, seen_d;
   logic [31:0] prdata_q, prdata_d;

   // Operating mode decode; the clock keeps running in every stop mode.
   wire run = (stop_mode == MODE_RUN);
   wire stop3 = (stop_mode == MODE_STOP3);
   wire lost = (stop_mode == MODE_STOP1) || (stop_mode == MODE_STOP2);

   // Bus decode; the slave always answers in the access cycle.
   wire hit_s1 = (paddr == OFF_STATUS1);
   wire hit_s2 = (paddr == OFF_STATUS2);
   wire hit_c1 = (paddr == OFF_CTRL1);
   wire hit_c2 = (paddr == OFF_CTRL2);
   wire hit_c3 = (paddr == OFF_CTRL3);
   wire hit_dt = (paddr == OFF_DATA);
   wire hit = hit_s1 | hit_s2 | hit_c1 | hit_c2 | hit_c3 | hit_dt;
   wire setup = psel & ~penable;
   wire acc = psel & penable & run & hit;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire data_wr = wr & hit_dt;
   wire data_rd = rd & hit_dt;
   wire s1_rd = rd & hit_s1;

   // Control fields.
   wire loop_en = ctrl1_q[C1_LOOP];
   wire rx_source_select = ctrl1_q[C1_RX_SOURCE_SELECT];
   wire wl9 = ctrl1_q[C1_WL];
   wire sw_dir = ctrl3_q[C3_DIR];
   wire rx_on = ctrl2_q[C2_RX_ON];

   // Receive input routing: pin, internal loop, or the shared output wire.
   wire single_wire = loop_en & rx_source_select;
   wire rx_route = ~loop_en ? serial_in_pin :
                   (~rx_source_select | sw_dir) ? tx_serial : serial_out_i;
   wire rx_fall = rx_on & rx_prev_q & ~rx_route;
   wire edge_evt = (run | stop3) & rx_fall;

   // Receive and transmit events.
   wire rx_take = run & rx_char_ready & ~rx_buffer_full_q;
   wire rx_over = run & rx_char_ready & rx_buffer_full_q;
   wire tx_move = run & tx_load & ~txe_q;
   wire idle_evt = run & rx_idle_detect & idle_arm_q;

   // Status-then-data clearing: a data read clears what the status read saw.
   wire [5:0] clr = data_rd ? seen_q : 6'h00;

   // Register views for reading.
   wire [7:0] s1_view = {txe_q, tc_q, rx_buffer_full_q, idle_q, ovr_q, nf_q, fe_q, pf_q};
   wire [7:0] s2_view = {brk_q, edge_q, 6'h00};
   wire [7:0] c3_view = {rx_ninth_q, ctrl3_q[6:0]};
   wire [7:0] rd_byte = hit_s1 ? s1_view : hit_s2 ? s2_view : hit_c1 ? ctrl1_q :
                        hit_c2 ? ctrl2_q : hit_c3 ? c3_view : hit_dt ? rx_data_q : 8'h00;

   // Next-state logic; stop1/stop2 lose everything, stop3 holds all but the edge detector.
   always_comb begin
      ctrl1_d = ctrl1_q;
      ctrl2_d = ctrl2_q;
      ctrl3_d = ctrl3_q;
      tx_buf_d = tx_buf_q;
      rx_data_d = rx_data_q;
      tx_shift_d = tx_shift_q;
      rx_ninth_d = rx_ninth_q;
      txe_d = txe_q;
      tc_d = tc_q;
      rx_buffer_full_d = rx_buffer_full_q;
      idle_d = idle_q;
      ovr_d = ovr_q;
      nf_d = nf_q;
      fe_d = fe_q;
      pf_d = pf_q;
      edge_d = edge_q | edge_evt;
      brk_d = brk_q;
      idle_arm_d = idle_arm_q;
      rx_prev_d = (run | stop3) ? rx_route : rx_prev_q;
      seen_d = seen_q;
      prdata_d = prdata_q;
      if (lost) begin
         ctrl1_d = CTRL_RST;
         ctrl2_d = CTRL_RST;
         ctrl3_d = CTRL_RST;
         tx_buf_d = DATA_RST;
         rx_data_d = DATA_RST;
         tx_shift_d = 9'h000;
         rx_ninth_d = FLAG_RST;
         txe_d = TXE_RST;
         tc_d = TC_RST;
         rx_buffer_full_d = FLAG_RST;
         idle_d = FLAG_RST;
         ovr_d = FLAG_RST;
         nf_d = FLAG_RST;
         fe_d = FLAG_RST;
         pf_d = FLAG_RST;
         edge_d = FLAG_RST;
         brk_d = FLAG_RST;
         idle_arm_d = FLAG_RST;
         rx_prev_d = 1'b1;
         seen_d = 6'h00;
         prdata_d = RDATA_RST;
      end else if (run) begin
         if (setup) begin
            prdata_d = {24'h000000, rd_byte};
         end
         if (wr & hit_c1) begin
            ctrl1_d = pwdata[7:0] & C1_WMASK;
         end
         if (wr & hit_c2) begin
            ctrl2_d = pwdata[7:0] & C2_WMASK;
         end
         if (wr & hit_c3) begin
            ctrl3_d = pwdata[7:0] & C3_WMASK;
         end
         // Writing one clears; a coincident event keeps the flag set.
         if (wr & hit_s2 & pwdata[S2_EDGE]) begin
            edge_d = edge_evt;
         end
         brk_d = break_detect | (brk_q & ~(wr & hit_s2 & pwdata[S2_BRK]));
         // Transmit buffer: a write fills it, a load moves byte and ninth bit.
         if (tx_move) begin
            tx_shift_d = {wl9 & ctrl3_q[C3_T9], tx_buf_q};
         end
         if (data_wr) begin
            tx_buf_d = pwdata[7:0];
            txe_d = 1'b0;
            tc_d = 1'b0;
         end else begin
            txe_d = txe_q | tx_move;
            tc_d = tc_q | (tx_idle & txe_q & ~tx_move);
         end
         // Receive side flags; hardware sets win over the read clear.
         if (rx_take) begin
            rx_data_d = rx_char[7:0];
            rx_ninth_d = wl9 & rx_char[8];
         end
         rx_buffer_full_d = rx_take | (rx_buffer_full_q & ~clr[S1_RX_BUFFER_FULL]);
         idle_d = idle_evt | (idle_q & ~clr[S1_IDLE]);
         idle_arm_d = rx_take | (idle_arm_q & ~idle_evt);
         ovr_d = rx_over | (ovr_q & ~clr[S1_OVR]);
         nf_d = (rx_take & rx_noise_err) | (nf_q & ~clr[S1_NOISE]);
         fe_d = (rx_take & rx_frame_err) | (fe_q & ~clr[S1_FRAME]);
         pf_d = (rx_take & rx_parity_err) | (pf_q & ~clr[S1_PARITY]);
         // A status read remembers which flags it saw set.
         if (data_rd) begin
            seen_d = 6'h00;
         end else if (s1_rd) begin
            seen_d = prdata_q[5:0];
         end
      end
   end

   // State registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_q <= CTRL_RST;
         ctrl2_q <= CTRL_RST;
         ctrl3_q <= CTRL_RST;
         tx_buf_q <= DATA_RST;
         rx_data_q <= DATA_RST;
         tx_shift_q <= 9'h000;
         rx_ninth_q <= FLAG_RST;
         txe_q <= TXE_RST;
         tc_q <= TC_RST;
         rx_buffer_full_q <= FLAG_RST;
         idle_q <= FLAG_RST;
         ovr_q <= FLAG_RST;
         nf_q <= FLAG_RST;
         fe_q <= FLAG_RST;
         pf_q <= FLAG_RST;
         edge_q <= FLAG_RST;
         brk_q <= FLAG_RST;
         idle_arm_q <= FLAG_RST;
         rx_prev_q <= 1'b1;
         seen_q <= 6'h00;
         prdata_q <= RDATA_RST;
      end else begin
         ctrl1_q <= ctrl1_d;
         ctrl2_q <= ctrl2_d;
         ctrl3_q <= ctrl3_d;
         tx_buf_q <= tx_buf_d;
         rx_data_q <= rx_data_d;
         tx_shift_q <= tx_shift_d;
         rx_ninth_q <= rx_ninth_d;
         txe_q <= txe_d;
         tc_q <= tc_d;
         rx_buffer_full_q <= rx_buffer_full_d;
         idle_q <= idle_d;
         ovr_q <= ovr_d;
         nf_q <= nf_d;
         fe_q <= fe_d;
         pf_q <= pf_d;
         edge_q <= edge_d;
         brk_q <= brk_d;
         idle_arm_q <= idle_arm_d;
         rx_prev_q <= rx_prev_d;
         seen_q <= seen_d;
         prdata_q <= prdata_d;
      end
   end

   // Interrupt lines, each an OR of enabled member flags.
   assign irq_tx = (txe_q & ctrl2_q[C2_TXE_IE]) | (tc_q & ctrl2_q[C2_TC_IE]);
   assign irq_rx = (rx_buffer_full_q & ctrl2_q[C2_RX_BUFFER_FULL_IE]) | (idle_q & ctrl2_q[C2_IDLE_IE]) |
                   (edge_q & ctrl1_q[C1_EDGE_IE]) | (brk_q & ctrl1_q[C1_BRK_IE]);
   assign irq_err = (ovr_q & ctrl3_q[C3_OVR_IE]) | (nf_q & ctrl3_q[C3_NOISE_IE]) |
                    (fe_q & ctrl3_q[C3_FRAME_IE]) | (pf_q & ctrl3_q[C3_PARITY_IE]);

   // Stop3 wake works without a clock: it compares the held level to the line.
   assign wake_req = stop3 & rx_fall & ctrl1_q[C1_EDGE_IE];

   // Pin and engine outputs.
   assign serial_out_o = tx_serial;
   assign serial_out_oe = ~single_wire | sw_dir;
   assign serial_in_released = loop_en;
   assign rx_serial = rx_route;
   assign rx_enable = rx_on;
   assign nine_bit_mode = wl9;
   assign tx_buf_valid = ~txe_q;
   assign tx_shift_data = tx_shift_q;
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // Checks on the flag and routing behaviour.
   property p_tx_irq;
      @(posedge pclk) disable iff (!presetn)
      (txe_q && ctrl2_q[C2_TXE_IE]) |-> irq_tx;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("Transmit interrupt missing while buffer empty.");

   property p_tc_cause;
      @(posedge pclk) disable iff (!presetn || lost)
      $rose(tc_q) |-> $past(tx_idle) && $past(txe_q);
   endproperty
   a_tc_cause: assert property (p_tc_cause) else $error("Done flag set while transmitter busy.");

   property p_rx_buffer_full_clear;
      @(posedge pclk) disable iff (!presetn || lost)
      (s1_rd && prdata_q[S1_RX_BUFFER_FULL]) ##[1:4] (data_rd && !rx_char_ready) |=> !rx_buffer_full_q;
   endproperty
   a_rx_buffer_full_clear: assert property (p_rx_buffer_full_clear) else $error("Receive-full not cleared by read pair.");

   property p_idle_rearm;
      @(posedge pclk) disable iff (!presetn || lost)
      $rose(idle_q) |-> $past(idle_arm_q);
   endproperty
   a_idle_rearm: assert property (p_idle_rearm) else $error("Idle set without a new character.");

   property p_err_with_rx_buffer_full;
      @(posedge pclk) disable iff (!presetn || lost)
      ($rose(nf_q) || $rose(fe_q) || $rose(pf_q)) |-> $rose(rx_buffer_full_q);
   endproperty
   a_err_with_rx_buffer_full: assert property (p_err_with_rx_buffer_full) else $error("Error flag set apart from receive-full.");

   property p_overrun;
      @(posedge pclk) disable iff (!presetn || lost)
      (rx_over && !data_rd) |=> ovr_q && $stable(rx_data_q) && $stable(nf_q) && $stable(fe_q);
   endproperty
   a_overrun: assert property (p_overrun) else $error("Overrun did not keep old character.");

   property p_edge;
      @(posedge pclk) disable iff (!presetn || lost)
      (run && rx_fall) |=> edge_q [*2];
   endproperty
   a_edge: assert property (p_edge) else $error("Receive edge did not set the edge flag.");

   property p_ninth;
      @(posedge pclk) disable iff (!presetn || lost)
      (tx_move && wl9) |=> tx_shift_data[8] == $past(ctrl3_q[C3_T9]) && tx_buf_valid == $past(data_wr);
   endproperty
   a_ninth: assert property (p_ninth) else $error("Ninth bit not copied at load.");

   property p_loop;
      @(posedge pclk) disable iff (!presetn)
      (loop_en && (!rx_source_select || sw_dir)) |-> rx_serial == tx_serial && serial_in_released;
   endproperty
   a_loop: assert property (p_loop) else $error("Receiver not fed by transmitter in loop.");

   property p_listen;
      @(posedge pclk) disable iff (!presetn)
      (single_wire && !sw_dir) |-> !serial_out_oe && rx_serial == serial_out_i;
   endproperty
   a_listen: assert property (p_listen) else $error("Pin driven while listening.");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      wake_req |-> (stop3 && rx_on && ctrl1_q[C1_EDGE_IE]) ##1 edge_q;
   endproperty
   a_wake: assert property (p_wake) else $error("Wake outside enabled stop3.");

   // Main scenarios worth seeing.
   c_overrun: cover property (@(posedge pclk) disable iff (!presetn) rx_over);
   c_idle: cover property (@(posedge pclk) disable iff (!presetn) idle_evt);
   c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_req);
   c_clear: cover property (@(posedge pclk) disable iff (!presetn) s1_rd ##1 data_rd);
endmodule : ufl_top

// *** verilog/ufl_pkg.sv ***
package ufl_pkg;
   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte offsets.
   localparam logic [7:0] OFF_STATUS1 = 8'h00;
   localparam logic [7:0] OFF_STATUS2 = 8'h04;
   localparam logic [7:0] OFF_CTRL1 = 8'h08;
   localparam logic [7:0] OFF_CTRL2 = 8'h0c;
   localparam logic [7:0] OFF_CTRL3 = 8'h10;
   localparam logic [7:0] OFF_DATA = 8'h14;
   // Status 1 field positions; bits 5 to 0 clear by the status-then-data read.
   localparam int S1_TXE = 7;
   localparam int S1_TC = 6;
   localparam int S1_RX_BUFFER_FULL = 5;
   localparam int S1_IDLE = 4;
   localparam int S1_OVR = 3;
   localparam int S1_NOISE = 2;
   localparam int S1_FRAME = 1;
   localparam int S1_PARITY = 0;
   // Status 2 field positions, both write one to clear.
   localparam int S2_BRK = 7;
   localparam int S2_EDGE = 6;
   // Control 1 field positions.
   localparam int C1_LOOP = 7;
   localparam int C1_RX_SOURCE_SELECT = 5;
   localparam int C1_WL = 4;
   localparam int C1_EDGE_IE = 1;
   localparam int C1_BRK_IE = 0;
   localparam logic [7:0] C1_WMASK = 8'hb3;
   // Control 2 field positions.
   localparam int C2_TXE_IE = 7;
   localparam int C2_TC_IE = 6;
   localparam int C2_RX_BUFFER_FULL_IE = 5;
   localparam int C2_IDLE_IE = 4;
   localparam int C2_RX_ON = 2;
   localparam logic [7:0] C2_WMASK = 8'hf4;
   // Control 3 field positions; bit 7 is the read-only received ninth bit.
   localparam int C3_R9 = 7;
   localparam int C3_T9 = 6;
   localparam int C3_DIR = 5;
   localparam int C3_OVR_IE = 3;
   localparam int C3_NOISE_IE = 2;
   localparam int C3_FRAME_IE = 1;
   localparam int C3_PARITY_IE = 0;
   localparam logic [7:0] C3_WMASK = 8'h6f;
   // Values after reset.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic TXE_RST = 1'b1;
   localparam logic TC_RST = 1'b1;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // Low-power mode codes on stop_mode.
   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_STOP1 = 2'h1;
   localparam logic [1:0] MODE_STOP2 = 2'h2;
   localparam logic [1:0] MODE_STOP3 = 2'h3;
endpackage : ufl_pkg

// *** tb/ufl_far_tx.sv ***
`timescale 1ns/10ps
// Far-side transmit shifter: takes the buffer after a short or long delay and sends it as an NRZ frame.
module ufl_far_tx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic tx_buf_valid,
   input wire logic [8:0] tx_shift_data,
   output logic tx_load,
   output logic tx_idle,
   output logic tx_serial,
   output logic [8:0] last_q
);
   logic [3:0] wait_q;
   logic [3:0] bit_q;
   logic [9:0] sh_q;
   logic cap_q;
   // Idle only when no frame is on the line and no load or capture is in flight.
   assign tx_idle = (bit_q == 4'h0) && !tx_load && !cap_q;
   // The block registers the handed word at the load edge, so it is taken one cycle later.
   // Then start bit, nine data bits and the stop bit go out; the line rests high between frames.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 4'h0;
         bit_q <= 4'h0;
         sh_q <= 10'h3ff;
         tx_load <= 1'h0;
         tx_serial <= 1'h1;
         last_q <= 9'h000;
         cap_q <= 1'h0;
      end else begin
         tx_load <= 1'h0;
         cap_q <= tx_load;
         if (cap_q) begin
            sh_q <= {tx_shift_data, 1'h0};
            last_q <= tx_shift_data;
            bit_q <= 4'hb;
         end else if (bit_q != 4'h0) begin
            tx_serial <= sh_q[0];
            sh_q <= {1'h1, sh_q[9:1]};
            bit_q <= bit_q - 4'h1;
         end else if (!tx_load) begin
            tx_serial <= 1'h1;
            if (tx_buf_valid) begin
               wait_q <= wait_q + 4'h1;
               if (wait_q >= (slow ? 4'h6 : 4'h1)) begin
                  tx_load <= 1'h1;
                  wait_q <= 4'h0;
               end
            end
         end
      end
   end
endmodule : ufl_far_tx

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   import ufl_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
   logic rx_char_ready = 1'h0, rx_noise_err = 1'h0, rx_frame_err = 1'h0, rx_parity_err = 1'h0;
   logic rx_idle_detect = 1'h0, break_detect = 1'h0, serial_in_pin = 1'h1, ext_line = 1'h1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [8:0] rx_char = 9'h000;
   logic [1:0] stop_mode = 2'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, tx_load, tx_idle, tx_serial, tx_buf_valid, rx_serial, rx_enable, nine_bit_mode;
   logic serial_in_released, serial_out_o, serial_out_oe, serial_out_i, wake_req, irq_tx, irq_rx, irq_err, err_q;
   logic [8:0] tx_shift_data, last_q;
   int err_total = 0, check_count = 0;
   always #20 pclk = ~pclk;
   // The shared pin carries the module's drive when enabled, otherwise the remote party's level.
   assign serial_out_i = serial_out_oe ? serial_out_o : ext_line;
   ufl_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .tx_load, .tx_idle, .tx_serial, .tx_buf_valid, .tx_shift_data, .rx_char_ready, .rx_char, .rx_noise_err,
      .rx_frame_err, .rx_parity_err, .rx_idle_detect, .break_detect, .rx_serial, .rx_enable, .nine_bit_mode,
      .serial_in_pin, .serial_in_released, .serial_out_i, .serial_out_o, .serial_out_oe, .stop_mode, .wake_req,
      .irq_tx, .irq_rx, .irq_err);
   ufl_far_tx far (.pclk, .presetn, .slow, .tx_buf_valid, .tx_shift_data, .tx_load, .tx_idle, .tx_serial, .last_q);
   task end_sim;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // One APB transfer; read data and error are taken at the edge where pready is seen.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 16) begin
         err_total++;
         end_sim();
      end
      // Outputs are compared half a period later, once the access edge has settled.
      @(negedge pclk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask : wr
   task rc(input logic [7:0] a, input logic [7:0] e);
      apb(1'h0, a, 32'h0);
      `CHK(rd, {24'h0, e})
   endtask : rc
   // Pulses {break, idle, character ready} for one cycle with a character and its error qualifiers.
   task strobe(input logic [2:0] k, input logic [8:0] c, input logic [2:0] e);
      @(posedge pclk);
      rx_char <= c;
      {rx_noise_err, rx_frame_err, rx_parity_err} <= e;
      {break_detect, rx_idle_detect, rx_char_ready} <= k;
      @(posedge pclk);
      {break_detect, rx_idle_detect, rx_char_ready} <= 3'h0;
      @(negedge pclk);
   endtask : strobe
   task wait_for(input int which);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((which == 0 ? tx_load : tx_idle) !== 1'h1 && n < 60);
      if (n >= 60) begin
         err_total++;
         end_sim();
      end
   endtask : wait_for
   task follow;
      wr(OFF_DATA, 8'h0f);
      repeat (24) @(negedge pclk) `CHK({rx_serial, serial_out_o}, {2{tx_serial}})
   endtask : follow
   task t_reset;
      rc(OFF_STATUS1, 8'hc0);
      rc(OFF_CTRL3, 8'h00);
      apb(1'h0, 8'h40, 32'h0);
      `CHK({err_q, rd}, {1'h1, 32'h0})
      `CHK({irq_tx, irq_rx, irq_err}, 3'h0)
   endtask : t_reset
   task t_tx;
      wr(OFF_CTRL1, 8'h10);
      wr(OFF_CTRL3, 8'h40);
      wr(OFF_CTRL2, 8'h80);
      `CHK(irq_tx, 1'h1)
      for (int i = 0; i < 2; i++) begin
         slow <= i[0];
         wr(OFF_DATA, 8'h5a + 8'(i));
         wait_for(0);
         rc(OFF_STATUS1, 8'h80);
         wait_for(1);
         repeat (2) @(posedge pclk);
         rc(OFF_STATUS1, 8'hc0);
         `CHK(last_q, {1'h1, 8'h5a + 8'(i)})
      end
      wr(OFF_CTRL2, 8'h00);
      `CHK(irq_tx, 1'h0)
      wr(OFF_CTRL2, 8'h40);
      `CHK(irq_tx, 1'h1)
   endtask : t_tx
   task t_rx;
      wr(OFF_CTRL2, 8'h24);
      wr(OFF_CTRL3, 8'h42);
      `CHK({rx_enable, nine_bit_mode}, 2'h3)
      strobe(3'h1, 9'h1a5, 3'h2);
      `CHK({irq_rx, irq_err}, 2'h3)
      strobe(3'h1, 9'h033, 3'h1);
      rc(OFF_STATUS1, 8'hea);
      rc(OFF_DATA, 8'ha5);
      rc(OFF_CTRL3, 8'hc2);
      rc(OFF_STATUS1, 8'hc0);
      `CHK({irq_rx, irq_err}, 2'h0)
      strobe(3'h2, 9'h000, 3'h0);
      rc(OFF_STATUS1, 8'hd0);
      rc(OFF_DATA, 8'ha5);
      strobe(3'h2, 9'h000, 3'h0);
      rc(OFF_STATUS1, 8'hc0);
   endtask : t_rx
   task t_edge;
      wr(OFF_CTRL1, 8'h12);
      @(posedge pclk) serial_in_pin <= 1'h0;
      strobe(3'h4, 9'h000, 3'h0);
      rc(OFF_STATUS2, 8'hc0);
      `CHK(irq_rx, 1'h1)
      wr(OFF_STATUS2, 8'h40);
      rc(OFF_STATUS2, 8'h80);
      wr(OFF_STATUS2, 8'h80);
      @(posedge pclk) serial_in_pin <= 1'h1;
      wr(OFF_CTRL2, 8'h20);
      @(posedge pclk) serial_in_pin <= 1'h0;
      rc(OFF_STATUS2, 8'h00);
      @(posedge pclk) serial_in_pin <= 1'h1;
      wr(OFF_CTRL2, 8'h24);
   endtask : t_edge
   task t_loop;
      wr(OFF_CTRL1, 8'h80);
      `CHK(serial_in_released, 1'h1)
      @(posedge pclk) serial_in_pin <= 1'h0;
      follow();
      wr(OFF_CTRL1, 8'ha0);
      wr(OFF_CTRL3, 8'h20);
      `CHK({serial_in_released, serial_out_oe}, 2'h3)
      follow();
      wr(OFF_CTRL3, 8'h00);
      `CHK(serial_out_oe, 1'h0)
      @(posedge pclk) ext_line <= 1'h0;
      @(negedge pclk) `CHK(rx_serial, 1'h0)
      @(posedge pclk);
      ext_line <= 1'h1;
      serial_in_pin <= 1'h1;
      wr(OFF_CTRL1, 8'h02);
      wr(OFF_STATUS2, 8'h40);
   endtask : t_loop
   task t_stop;
      // Stop is entered only with both directions quiet.
      wait_for(1);
      @(posedge pclk) stop_mode <= MODE_STOP3;
      repeat (3) @(posedge pclk);
      serial_in_pin <= 1'h0;
      @(negedge pclk) `CHK(wake_req, 1'h1)
      @(posedge pclk) stop_mode <= MODE_RUN;
      rc(OFF_CTRL1, 8'h02);
      rc(OFF_STATUS2, 8'h40);
      @(posedge pclk) serial_in_pin <= 1'h1;
      @(posedge pclk) stop_mode <= MODE_STOP2;
      @(posedge pclk) serial_in_pin <= 1'h0;
      @(negedge pclk) `CHK(wake_req, 1'h0)
      @(posedge pclk) stop_mode <= MODE_RUN;
      rc(OFF_CTRL1, 8'h00);
      rc(OFF_STATUS2, 8'h00);
   endtask : t_stop
   // Main sequence: reset for 20 cycles, then each scenario in turn.
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_tx();
      t_rx();
      t_edge();
      t_loop();
      t_stop();
      end_sim();
   end
endmodule : tb_top
